// file: pkg/bfws_pkg.sv
// package: register map, field positions, reset values and timing constants of the supervisor
package bfws_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // times in their own unit
  localparam int unsigned BROWNOUT_FILTER_TIME_US = 10;
  localparam int unsigned OVERVOLTAGE_FILTER_TIME_US = 10;
  localparam int unsigned THERMAL_FILTER_TIME_US = 10;
  localparam int unsigned THERMAL_BLANK_INTERVAL_US = 100;
  localparam int unsigned RECOVERY_TIME_MS10 = 80; // 0.8 s in units of 10 ms
  // derived cycle counts (the clock ratio is an integer division and truncates)
  localparam int unsigned BO_FILT_CYC = (BROWNOUT_FILTER_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned OV_FILT_CYC = (OVERVOLTAGE_FILTER_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned OT_FILT_CYC = (THERMAL_FILTER_TIME_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BLANK_CYC = (THERMAL_BLANK_INTERVAL_US * (CLK_HZ / 1_000_000));
  localparam int unsigned RECOVERY_CYC = (RECOVERY_TIME_MS10 * (CLK_HZ / 100));
  localparam int unsigned TW = 32;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  // control fields
  localparam int unsigned CTRL_LATCH_OV = 0;
  localparam int unsigned CTRL_LATCH_OT = 1;
  localparam int unsigned CTRL_SKIP_BIAS = 2;
  localparam logic [2:0] CTRL_RST = 3'h5; // ov latched, ot auto, bias kept in skip
  // event bits
  localparam int unsigned EV_BO_RISE = 0;
  localparam int unsigned EV_BO_FALL = 1;
  localparam int unsigned EV_OV = 2;
  localparam int unsigned EV_OT = 3;
  localparam int unsigned EV_RESTART = 4;
  localparam int unsigned NEV = 5;
  localparam logic [NEV-1:0] MASK_RST = 5'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [3:0] {
    BFWS_OFF = 4'h1,
    BFWS_RUN = 4'h2,
    BFWS_WAIT = 4'h4,
    BFWS_LATCH = 4'h8
  } bfws_state_t;
endpackage

// file: pkg/bfws_filt_if.sv
// interface: one comparator filter's input and qualified output
`timescale 1ns/1ps
interface bfws_filt_if;
  logic raw;
  logic clr;
  logic qual;
  modport ctl (output raw, output clr, input qual);
  modport flt (input raw, input clr, output qual);
endinterface

// file: core/bfws_filter.sv
// consecutive-sample noise filter for one comparator flag
`timescale 1ns/1ps
module bfws_filter import bfws_pkg::*; #(
  parameter int unsigned CYC = 1000
) (
  input wire logic clk,
  input wire logic rst,
  bfws_filt_if.flt f
);
  logic [TW-1:0] cnt_q;
  logic last_q;
  logic qual_q;
  wire logic same = (f.raw == last_q);
  wire logic done = same && (cnt_q >= TW'(CYC - 1));
  // count agreeing samples, restart on change
  always_ff @(posedge clk) begin
    if (rst || f.clr) begin
      cnt_q <= '0;
      last_q <= 1'b0;
      qual_q <= 1'b0;
    end else begin
      last_q <= f.raw;
      cnt_q <= same ? (done ? cnt_q : cnt_q + TW'(1)) : '0; // R17
      if (done) begin
        qual_q <= last_q; // R4 R8
      end
    end
  end
  assign f.qual = qual_q;
endmodule

// file: core/bfws_top.sv
// brown-out and fault window supervisor with an ahb-lite register slave
// Operation
// R1 - hysteresis sink on while bulk good low; off while good and running
// R2 - bulk sense held low by discharge switch during supply startup
// R3 - on start level: sink on and discharge released together
// R4 - brown-out comparator filtered before updating bulk good flag
// R5 - power stage switching allowed only while filtered bulk good high
// R6 - run only while fault input inside lower/upper thresholds
// R7 - filtered excursion stops run, then latch or recovery timer
// R8 - overvoltage and thermal comparators use separate filters
// R9 - thermal comparator ignored during startup blanking interval
// R10 - boosted double bias selected during blanking interval
// R11 - fault block enabled on start, bulk good rise, restart, skip exit
// R12 - bias off on stop level, bulk low, fault, skip entry
// R13 - option keeps fault block biased in skip mode
// R14 - latched fault stays until supply falls below clear level
// R15 - external circuit must overdrive soft clamp to raise overvoltage
// R16 - one common recovery timer of 0.8 s for all faults
// R17 - filters count consecutive agreeing samples, restart on change
// R18 - supply clear returns all states, filters, timers to idle
`timescale 1ns/1ps
module bfws_top import bfws_pkg::*; #(
  parameter int unsigned BO_CYC = BO_FILT_CYC,
  parameter int unsigned OV_CYC = OV_FILT_CYC,
  parameter int unsigned OT_CYC = OT_FILT_CYC,
  parameter int unsigned BLANK_CYCLES = BLANK_CYC,
  parameter int unsigned RECOVERY_CYCLES = RECOVERY_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic SUPPLY_START,
  input wire logic SUPPLY_STOP,
  input wire logic BROWNOUT_CMP,
  input wire logic OVERVOLTAGE_CMP,
  input wire logic THERMAL_CMP,
  input wire logic SKIP_ENTRY,
  input wire logic SKIP_EXIT,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic SWITCH_ENABLE,
  output logic HYSTERESIS_SINK_ON,
  output logic DISCHARGE_ON,
  output logic BIAS_ON,
  output logic BIAS_BOOST,
  output logic FAULT_LATCHED,
  output logic IRQ
);
  // RST is the supply-clear reset for the whole block
  bfws_filt_if bo_if();
  bfws_filt_if ov_if();
  bfws_filt_if ot_if();
  bfws_state_t st_q, st_d;
  logic started_q;
  logic bias_q;
  logic skip_q;
  logic [TW-1:0] blank_q;
  logic [TW-1:0] rec_q;
  logic good_prev_q;
  logic [2:0] ctrl_q;
  logic [NEV-1:0] ev_q;
  logic [NEV-1:0] mask_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;
  logic [TW-1:0] sk_cnt_q;

  // filters
  bfws_filter #(.CYC(BO_CYC)) u_bo (.clk(SYS_CLK), .rst(RST), .f(bo_if));
  bfws_filter #(.CYC(OV_CYC)) u_ov (.clk(SYS_CLK), .rst(RST), .f(ov_if));
  bfws_filter #(.CYC(OT_CYC)) u_ot (.clk(SYS_CLK), .rst(RST), .f(ot_if));

  wire logic bulk_level_good = bo_if.qual;
  wire logic blanking = (blank_q != '0);
  wire logic ov_fault = ov_if.qual;
  wire logic ot_fault = ot_if.qual && !blanking; // R9
  wire logic window_fault = bias_q && (ov_fault || ot_fault); // R6
  wire logic good_rise = bulk_level_good && !good_prev_q;
  wire logic good_fall = !bulk_level_good && good_prev_q;
  wire logic latch_sel = (ov_fault && ctrl_q[CTRL_LATCH_OV]) ||
                         (ot_fault && ctrl_q[CTRL_LATCH_OT]);
  wire logic rec_done = (st_q == BFWS_WAIT) && (rec_q == TW'(1));
  // a skip exit re-biases even with the kill option, so the kill must not hold it off
  wire logic skip_kill = skip_q && !SKIP_EXIT && !ctrl_q[CTRL_SKIP_BIAS]; // R13
  wire logic first_start = SUPPLY_START && !started_q;
  wire logic bias_set = first_start || good_rise || rec_done ||
                        (SKIP_EXIT && skip_q); // R11
  wire logic bias_clr = SUPPLY_STOP || good_fall || window_fault ||
                        (SKIP_ENTRY && !ctrl_q[CTRL_SKIP_BIAS]); // R12

  // filter inputs; ot filter is flushed while blanked
  assign bo_if.raw = BROWNOUT_CMP && started_q;
  assign bo_if.clr = 1'b0;
  assign ov_if.raw = OVERVOLTAGE_CMP; // R15
  assign ov_if.clr = !bias_q;
  assign ot_if.raw = THERMAL_CMP;
  assign ot_if.clr = !bias_q || blanking; // R9

  // protection state machine
  always_comb begin
    st_d = st_q;
    case (st_q)
      BFWS_OFF: begin
        if (started_q && bulk_level_good) begin
          st_d = BFWS_RUN;
        end
      end
      BFWS_RUN: begin
        if (window_fault) begin
          st_d = latch_sel ? BFWS_LATCH : BFWS_WAIT; // R7
        end else if (!bulk_level_good || SUPPLY_STOP) begin
          st_d = BFWS_OFF;
        end
      end
      BFWS_WAIT: begin
        if (rec_done) begin
          st_d = BFWS_OFF; // R16
        end
      end
      BFWS_LATCH: st_d = BFWS_LATCH; // R14
      default: st_d = BFWS_OFF;
    endcase
  end

  // state, supply start and bulk edge tracking
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_q <= BFWS_OFF; // R18
      started_q <= 1'b0;
      good_prev_q <= 1'b0;
    end else begin
      st_q <= st_d;
      started_q <= started_q || SUPPLY_START; // R2 R3
      good_prev_q <= bulk_level_good;
    end
  end

  // bias enable, skip tracking and blanking window
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      bias_q <= 1'b0;
      skip_q <= 1'b0;
      blank_q <= '0;
    end else begin
      if (SKIP_ENTRY) begin
        skip_q <= 1'b1;
      end else if (SKIP_EXIT) begin
        skip_q <= 1'b0;
      end
      if (bias_clr || skip_kill) begin
        bias_q <= 1'b0;
        blank_q <= '0;
      end else if (bias_set && st_q != BFWS_LATCH) begin
        bias_q <= 1'b1;
        blank_q <= TW'(BLANK_CYCLES); // R10
      end else if (blanking) begin
        blank_q <= blank_q - TW'(1);
      end
    end
  end

  // common recovery timer
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rec_q <= '0;
    end else if (st_q == BFWS_RUN && st_d == BFWS_WAIT) begin
      rec_q <= TW'(RECOVERY_CYCLES); // R16
    end else if (rec_q != '0) begin
      rec_q <= rec_q - TW'(1);
    end
  end

  // pin outputs
  assign SWITCH_ENABLE = (st_q == BFWS_RUN) && bulk_level_good; // R5
  assign HYSTERESIS_SINK_ON = started_q && !(bulk_level_good && st_q == BFWS_RUN); // R1 R3
  assign DISCHARGE_ON = !started_q; // R2
  assign BIAS_ON = bias_q;
  assign BIAS_BOOST = bias_q && blanking; // R10
  assign FAULT_LATCHED = (st_q == BFWS_LATCH); // R14

  // ahb-lite slave: zero wait, always okay
  wire logic ahb_go = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
  wire logic [NEV-1:0] ev_in;
  assign ev_in[EV_BO_RISE] = good_rise;
  assign ev_in[EV_BO_FALL] = good_fall;
  assign ev_in[EV_OV] = window_fault && ov_fault;
  assign ev_in[EV_OT] = window_fault && ot_fault;
  assign ev_in[EV_RESTART] = rec_done;
  wire logic wr_ctrl = wr_pend_q && (addr_q == ADDR_CTRL);
  wire logic wr_ist = wr_pend_q && (addr_q == ADDR_IRQ_STAT);
  wire logic wr_msk = wr_pend_q && (addr_q == ADDR_IRQ_MASK);
  wire logic [NEV-1:0] ev_w1c = wr_ist ? HWDATA[NEV-1:0] : '0;
  wire logic [31:0] stat_word = {22'h00000, st_q, FAULT_LATCHED, BIAS_BOOST,
                                 BIAS_ON, SWITCH_ENABLE, bulk_level_good, started_q};
  wire logic [31:0] rd_mux = (HADDR[7:0] == ADDR_CTRL) ? {29'h0000000, ctrl_q} :
                             (HADDR[7:0] == ADDR_STAT) ? stat_word :
                             (HADDR[7:0] == ADDR_IRQ_STAT) ? {27'h000000, ev_q} :
                             (HADDR[7:0] == ADDR_IRQ_MASK) ? {27'h000000, mask_q} :
                             32'h00000000;

  // address phase capture and read data
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= ahb_go && HWRITE;
      rd_pend_q <= ahb_go && !HWRITE;
      if (ahb_go) begin
        addr_q <= HADDR[7:0];
      end
      if (ahb_go && !HWRITE) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // registers; hardware set wins over write-one clear
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
      ev_q <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= HWDATA[2:0];
      end
      if (wr_msk) begin
        mask_q <= HWDATA[NEV-1:0];
      end
      ev_q <= (ev_q & ~ev_w1c) | ev_in;
    end
  end

  assign HRDATA = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign IRQ = |(ev_q & mask_q);

  // helper: cycles spent in skip with bias kill option
  always_ff @(posedge SYS_CLK) begin
    if (RST || !skip_q || ctrl_q[CTRL_SKIP_BIAS]) begin
      sk_cnt_q <= '0;
    end else if (sk_cnt_q != '1) begin
      sk_cnt_q <= sk_cnt_q + TW'(1);
    end
  end

  // assertions
  property p_switch;
    @(posedge SYS_CLK) disable iff (RST) SWITCH_ENABLE |-> bulk_level_good;
  endproperty
  a_switch: assert property (p_switch) else $error("switching without bulk good"); // R5
  property p_sink;
    @(posedge SYS_CLK) disable iff (RST)
      (started_q && !bulk_level_good) |-> HYSTERESIS_SINK_ON;
  endproperty
  a_sink: assert property (p_sink) else $error("sink off while bulk low"); // R1
  property p_start;
    @(posedge SYS_CLK) disable iff (RST)
      (!started_q && SUPPLY_START) |=> (!DISCHARGE_ON && HYSTERESIS_SINK_ON);
  endproperty
  a_start: assert property (p_start) else $error("start step wrong"); // R3
  property p_disch;
    @(posedge SYS_CLK) disable iff (RST) !started_q |-> DISCHARGE_ON;
  endproperty
  a_disch: assert property (p_disch) else $error("discharge released early"); // R2
  property p_fault_stop;
    @(posedge SYS_CLK) disable iff (RST)
      (st_q == BFWS_RUN && window_fault) |=> !SWITCH_ENABLE;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("no stop on fault"); // R6 R7
  property p_latch;
    @(posedge SYS_CLK) disable iff (RST) FAULT_LATCHED |=> FAULT_LATCHED && !SWITCH_ENABLE;
  endproperty
  a_latch: assert property (p_latch) else $error("latch released"); // R14
  property p_boost;
    @(posedge SYS_CLK) disable iff (RST) BIAS_BOOST |-> (BIAS_ON && ot_if.clr);
  endproperty
  a_boost: assert property (p_boost) else $error("boost outside blanking"); // R9 R10
  property p_bias_off;
    @(posedge SYS_CLK) disable iff (RST) (SUPPLY_STOP || good_fall) |=> !BIAS_ON;
  endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias stays on"); // R12
  property p_skip_bias;
    @(posedge SYS_CLK) disable iff (RST)
      (skip_q && !ctrl_q[CTRL_SKIP_BIAS] && sk_cnt_q > TW'(1)) |-> !BIAS_ON;
  endproperty
  a_skip_bias: assert property (p_skip_bias) else $error("bias on in skip"); // R13
  property p_irq;
    @(posedge SYS_CLK) disable iff (RST) $rose(ev_q[EV_OV]) && mask_q[EV_OV] |-> IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
  c_run: cover property (@(posedge SYS_CLK) disable iff (RST) st_q == BFWS_RUN);
  c_wait: cover property (@(posedge SYS_CLK) disable iff (RST) rec_done);
  c_latch: cover property (@(posedge SYS_CLK) disable iff (RST) $rose(FAULT_LATCHED));
endmodule

// file: verification/bfws_sense_model.sv
// model of the external bulk divider and thermistor network around the supervisor
`timescale 1ns/1ps
module bfws_sense_model #(
  parameter logic [7:0] BO_REF = 8'h64,
  parameter logic [7:0] SINK_DROP = 8'h0A
) (
  input wire logic [7:0] bulk_lvl,
  input wire logic sink_on,
  input wire logic discharge_on,
  input wire logic ext_pull,
  input wire logic ntc_hot,
  input wire logic bias_on,
  output logic bo_cmp,
  output logic ov_cmp,
  output logic ot_cmp
);
  logic [7:0] sense;
  // discharge switch shorts the pin; the sink pulls it down by a fixed drop
  assign sense = discharge_on ? 8'h00 : bulk_lvl - (sink_on ? SINK_DROP : 8'h00);
  assign bo_cmp = sense > BO_REF;
  // the soft clamp keeps the bias alone below the upper level; only an outside pull-up trips
  assign ov_cmp = ext_pull;
  // a hot thermistor, or no bias at all, leaves the pin under the lower level
  assign ot_cmp = ntc_hot | ~bias_on;
endmodule

// file: verification/tb_bfws_top.sv
// self-checking testbench of the supervisor with its sensing network
`timescale 1ns/1ps
module tb_bfws_top import bfws_pkg::*; ();
  localparam int BO = 4;
  localparam int OV = 4;
  localparam int OT = 4;
  localparam int BL = 40;
  localparam int REC = 50;
  logic SYS_CLK;
  logic RST = 1'b1;
  logic ss = 1'b0;
  logic sstop = 1'b0;
  logic sken = 1'b0;
  logic skex = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] bulk = 8'h96;
  logic ext = 1'b0;
  logic hot = 1'b0;
  wire bo, ov, ot, rdy, resp, sw, sink, dis, bias, boost, lat, irq;
  wire [31:0] rd;
  int n_mismatch = 0;
  int num_checks = 0;
  int n;
  // design under test, with short counts
  bfws_top #(.BO_CYC(BO), .OV_CYC(OV), .OT_CYC(OT), .BLANK_CYCLES(BL),
    .RECOVERY_CYCLES(REC)) i_bfws_top (.SYS_CLK(SYS_CLK), .RST(RST),
    .SUPPLY_START(ss), .SUPPLY_STOP(sstop), .BROWNOUT_CMP(bo), .OVERVOLTAGE_CMP(ov),
    .THERMAL_CMP(ot), .SKIP_ENTRY(sken), .SKIP_EXIT(skex), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(rdy),
    .HRDATA(rd), .HREADYOUT(rdy), .HRESP(resp), .SWITCH_ENABLE(sw),
    .HYSTERESIS_SINK_ON(sink), .DISCHARGE_ON(dis), .BIAS_ON(bias), .BIAS_BOOST(boost),
    .FAULT_LATCHED(lat), .IRQ(irq));
  // far side: divider and thermistor
  bfws_sense_model i_bfws_sense_model (.bulk_lvl(bulk), .sink_on(sink),
    .discharge_on(dis), .ext_pull(ext), .ntc_hot(hot), .bias_on(bias),
    .bo_cmp(bo), .ov_cmp(ov), .ot_cmp(ot));
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end
  // waits k edges, then lets their updates land
  task cyc(input int k);
    repeat (k) @(posedge SYS_CLK);
    #1;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one single ahb-lite transfer, zero or more wait states
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge SYS_CLK);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    do @(posedge SYS_CLK); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge SYS_CLK); while (rdy !== 1'b1);
    q = rd;
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // one-cycle pulse on start, skip entry or skip exit
  task pulse(input int k);
    @(posedge SYS_CLK);
    if (k == 0) ss <= 1'b1; else if (k == 1) sken <= 1'b1; else skex <= 1'b1;
    @(posedge SYS_CLK);
    ss <= 1'b0;
    sken <= 1'b0;
    skex <= 1'b0;
    #1;
  endtask
  function logic pick(input int k);
    case (k)
      0: pick = sw;
      1: pick = dis;
      2: pick = bias;
      3: pick = boost;
      default: pick = lat;
    endcase
  endfunction
  // bounded wait for an output level, cycles counted in n
  task waitv(input int k, input logic v);
    n = 0;
    while (pick(k) !== v && n < 300) begin
      cyc(1);
      n++;
    end
  endtask
  task rng(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task t_reset;
    chk({dis, sw, sink, bias, lat, irq, rdy, resp}, 32'h82);
    rdc(ADDR_CTRL, 32'h5);
    rdc(ADDR_IRQ_MASK, 32'h0);
    rdc(ADDR_IRQ_STAT, 32'h0);
    rdc(8'h10, 32'h0);
    rdc(ADDR_STAT, 32'h40);
    chk(dis, 1'b1);
    $display("reset test done");
  endtask
  task t_start;
    pulse(0);
    waitv(1, 1'b0);
    chk(sink, 1'b1);
    waitv(0, 1'b1);
    rng(BO, BO + 5);
    chk(sink, 1'b0);
    chk({bias, boost}, 32'h3);
    @(posedge SYS_CLK) hot <= 1'b1;
    cyc(OT + 3);
    @(posedge SYS_CLK) hot <= 1'b0;
    waitv(3, 1'b0);
    chk({sw, bias}, 32'h3);
    rdc(ADDR_IRQ_STAT, 32'h01);
    $display("start test done");
  endtask
  task t_thermal;
    wr(ADDR_IRQ_STAT, 32'h1F);
    wr(ADDR_IRQ_MASK, 32'h08);
    @(posedge SYS_CLK) hot <= 1'b1;
    waitv(0, 1'b0);
    rng(OT, OT + 5);
    chk({bias, lat}, 32'h0);
    @(posedge SYS_CLK) hot <= 1'b0;
    chk(irq, 1'b1);
    waitv(2, 1'b1);
    rng(REC - 6, REC + 6);
    chk(boost, 1'b1);
    waitv(0, 1'b1);
    rng(0, 2 * BL);
    rdc(ADDR_IRQ_STAT, 32'h18);
    wr(ADDR_IRQ_MASK, 32'h0);
    cyc(1);
    chk(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 32'h08);
    wr(ADDR_IRQ_STAT, 32'h08);
    cyc(1);
    chk(irq, 1'b0);
    rdc(ADDR_IRQ_STAT, 32'h10);
    $display("thermal test done");
  endtask
  task t_skip;
    pulse(1);
    cyc(1);
    chk(bias, 1'b1);
    pulse(2);
    wr(ADDR_CTRL, 32'h1);
    pulse(1);
    cyc(1);
    chk(bias, 1'b0);
    pulse(2);
    cyc(1);
    chk(bias, 1'b1);
    wr(ADDR_CTRL, 32'h5);
    $display("skip test done");
  endtask
  task t_brownout;
    wr(ADDR_IRQ_STAT, 32'h1F);
    @(posedge SYS_CLK) bulk <= 8'h32;
    cyc(BO - 2);
    @(posedge SYS_CLK) bulk <= 8'h96;
    cyc(BO + 3);
    rdc(ADDR_IRQ_STAT, 32'h0);
    @(posedge SYS_CLK) bulk <= 8'h32;
    waitv(0, 1'b0);
    rng(BO, BO + 5);
    cyc(1);
    chk({sink, bias}, 32'h2);
    rdc(ADDR_IRQ_STAT, 32'h02);
    @(posedge SYS_CLK) bulk <= 8'h96;
    waitv(0, 1'b1);
    rng(BO, BO + 5);
    chk({sink, bias}, 32'h1);
    $display("brownout test done");
  endtask
  task t_latch;
    wr(ADDR_IRQ_MASK, 32'h04);
    @(posedge SYS_CLK) ext <= 1'b1;
    waitv(4, 1'b1);
    rng(OV, OV + 5);
    chk({sw, bias}, 32'h0);
    chk(irq, 1'b1);
    @(posedge SYS_CLK) ext <= 1'b0;
    cyc(REC + 20);
    pulse(0);
    cyc(2);
    chk({lat, sw}, 32'h2);
    @(posedge SYS_CLK) RST <= 1'b1;
    @(posedge SYS_CLK) RST <= 1'b0;
    cyc(1);
    chk({lat, dis, sw, bias}, 32'h4);
    rdc(ADDR_CTRL, 32'h5);
    pulse(0);
    waitv(0, 1'b1);
    rng(BO, BO + 8);
    @(posedge SYS_CLK) sstop <= 1'b1;
    cyc(3);
    chk({bias, sw}, 32'h0);
    $display("latch and stop test done");
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the whole run needs a few thousand cycles at most
  initial begin
    #200000;
    n_mismatch++;
    end_sim;
  end
  // main sequence
  initial begin
    repeat (6) @(posedge SYS_CLK);
    RST <= 1'b0;
    cyc(1);
    t_reset;
    t_start;
    t_thermal;
    t_skip;
    t_brownout;
    t_latch;
    end_sim;
  end
endmodule
